// >>> hw/lpm_ctrl.sv
// Low-power mode controller: mode selection, clock gating, supplies and wake-up
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module lpm_ctrl #(
    parameter int SUPPLY_RAMP_CYCLES = lpm_pkg::SUPPLY_RAMP_CYC,
    parameter int BACKUP_WAKE_CYCLES = lpm_pkg::BACKUP_WAKE_MAX_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [31:0] rd_data_out,
    // Processor core
    input  wire logic        wfi_in,
    input  wire logic        wfe_in,
    input  wire logic        deep_sleep_select_in,
    input  wire logic        irq_pending_in,
    input  wire logic        event_in,
    // Wake sources, active low
    input  wire logic [15:0] wake_pin_inputs_n_in,
    input  wire logic        supply_monitor_n_in,
    input  wire logic        rtc_alarm_n_in,
    input  wire logic        realtime_timer_alarm_n_in,
    // Clock control
    output logic             core_clk_en_out,
    output logic             periph_clk_en_out,
    output logic             mem_clk_en_out,
    output logic      [1:0]  master_clock_sel_out,
    output logic             fast_rc_osc_enable_out,
    output logic             pll_enable_out,
    // Supply control
    output logic             core_supply_en_out,
    output logic             sram_supply_en_out,
    output logic             regulator_en_out,
    output logic             gpio_hold_out,
    output logic             core_reset_out,
    // Status
    output logic             fast_startup_req_out,
    output logic             irq_out
);
    import lpm_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (SUPPLY_RAMP_CYCLES < 1 || SUPPLY_RAMP_CYCLES >= BACKUP_WAKE_CYCLES
        || SUPPLY_RAMP_CYCLES > 65535) begin : g_bad_ramp
        $error("Supply ramp must be shorter than the backup wake limit");
    end
    if (RC_START_CYC >= WAIT_WAKE_MAX_CYC) begin : g_bad_rc
        $error("Oscillator restart exceeds the wait wake limit");
    end

    lpm_state_t state;
    lpm_state_t next_state;
    logic [15:0] cnt;
    logic        by_wfi;
    logic [4:0]  ctrl;
    logic [18:0] wait_wake_en;
    logic [18:0] backup_wake_en;
    logic [2:0]  power_en;
    logic        core_supply;
    logic        sram_supply;
    logic [IRQ_N-1:0] irq_status;
    logic [IRQ_N-1:0] irq_enable;

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    wire logic [18:0] wake_n = {realtime_timer_alarm_n_in, rtc_alarm_n_in,
                                supply_monitor_n_in, wake_pin_inputs_n_in};
    // Backup mode has its own source mask; every other state uses the wait mask
    wire logic [18:0] wake_mask = (state == ST_BACKUP) ? backup_wake_en
                                : wait_wake_en;
    wire logic        fsr;

    lpm_fast_startup #(
        .N (WAKE_SRC_N)
    ) u_fast_startup (
        .wake_n_in            (wake_n),
        .wake_en_in           (wake_mask),
        .fast_startup_req_out (fsr)
    );

    wire logic lps        = ctrl[CTRL_LPS_BIT];
    wire logic sleep_wake = by_wfi ? irq_pending_in
                          : (irq_pending_in | event_in | fsr);
    wire logic wait_wake  = fsr | event_in;

    wire logic [15:0] resync_last = 16'(RESYNC_CYC - 1);
    wire logic [15:0] rc_last     = 16'(RC_START_CYC - 1);
    wire logic [15:0] ramp_last   = 16'(SUPPLY_RAMP_CYCLES - 1);

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_ACTIVE: begin
                if (wfe_in && deep_sleep_select_in) begin
                    next_state = ST_BACKUP;
                end else if (wfe_in && lps) begin
                    next_state = ST_RESYNC;
                end else if ((wfi_in || wfe_in) && !deep_sleep_select_in) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (sleep_wake) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_RESYNC: begin
                if (cnt == resync_last) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_wake) begin
                    next_state = ST_RC_RESTART;
                end
            end
            ST_RC_RESTART: begin
                if (cnt == rc_last) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_BACKUP: begin
                if (fsr) begin
                    next_state = ST_SUPPLY_UP;
                end
            end
            ST_SUPPLY_UP: begin
                if (cnt == ramp_last) begin
                    next_state = ST_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_ACTIVE;
            cnt   <= 16'h0000;
        end else begin
            state <= next_state;
            cnt   <= (next_state != state) ? 16'h0000 : cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            by_wfi <= 1'b0;
        end else if (state == ST_ACTIVE && next_state == ST_SLEEP) begin
            by_wfi <= wfi_in;
        end
    end

    // Core supply off in backup; SRAM kept only if asked
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_supply <= 1'b1;
            sram_supply <= 1'b1;
        end else if (state == ST_ACTIVE && next_state == ST_BACKUP) begin
            core_supply <= 1'b0;
            sram_supply <= power_en[PWR_SRAM_KEEP_BIT];
        end else if (state == ST_BACKUP && next_state == ST_SUPPLY_UP) begin
            if (!core_supply) begin
                core_supply <= 1'b1;
            end
            if (!sram_supply) begin
                sram_supply <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    wire logic wr_ctrl   = wr_en_in && addr_in == REG_CTRL;
    wire logic wr_wwake  = wr_en_in && addr_in == REG_WAIT_WAKE;
    wire logic wr_bwake  = wr_en_in && addr_in == REG_BACKUP_WAKE;
    wire logic wr_pwr    = wr_en_in && addr_in == REG_POWER_EN;
    wire logic wr_ien    = wr_en_in && addr_in == REG_IRQ_ENABLE;
    wire logic wr_iclr   = wr_en_in && addr_in == REG_IRQ_CLEAR;
    wire logic enter_wait = state == ST_RESYNC && next_state == ST_WAIT;
    // A wake from wait or backup lands on the fast RC with the PLL left stopped
    wire logic wake_done = (state == ST_RC_RESTART || state == ST_SUPPLY_UP)
                         && next_state == ST_ACTIVE;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl <= CTRL_RESET;
        end else if (wake_done) begin
            ctrl[CTRL_RCEN_BIT] <= 1'b1;
            ctrl[CTRL_CLKSEL_LSB +: 2] <= CLK_FAST_RC;
            ctrl[CTRL_PLLEN_BIT] <= 1'b0;
        end else if (enter_wait) begin
            // Firmware polls this bit to know the core has stopped
            ctrl[CTRL_RCEN_BIT] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl <= wr_data_in[4:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_wake_en   <= WAKE_EN_RESET;
            backup_wake_en <= WAKE_EN_RESET;
            power_en       <= POWER_EN_RESET;
            irq_enable     <= '0;
        end else begin
            if (wr_wwake) begin
                wait_wake_en <= wr_data_in[18:0];
            end
            if (wr_bwake) begin
                backup_wake_en <= wr_data_in[18:0];
            end
            if (wr_pwr) begin
                power_en <= wr_data_in[2:0];
            end
            if (wr_ien) begin
                irq_enable <= wr_data_in[IRQ_N-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire logic [IRQ_N-1:0] irq_event = {
        state == ST_SUPPLY_UP && wake_done,
        state == ST_RC_RESTART && wake_done,
        state == ST_SLEEP && sleep_wake};
    wire logic [IRQ_N-1:0] irq_clr = wr_iclr ? wr_data_in[IRQ_N-1:0] : '0;

    // A new event beats a clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_event;
        end
    end

    assign irq_out = |(irq_status & irq_enable);

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    wire logic [1:0] mode =
        (state == ST_SLEEP) ? MODE_SLEEP :
        (state == ST_WAIT || state == ST_RESYNC || state == ST_RC_RESTART) ? MODE_WAIT :
        (state == ST_BACKUP || state == ST_SUPPLY_UP) ? MODE_BACKUP : MODE_ACTIVE;
    wire logic [31:0] status_word = 32'(
        (32'(mode) << STAT_MODE_LSB) | (32'(core_supply) << STAT_CORE_BIT)
        | (32'(sram_supply) << STAT_SRAM_BIT) | (32'(fsr) << STAT_FSR_BIT));
    wire logic [31:0] rd_mux =
        (addr_in == REG_CTRL)        ? {27'h000_0000, ctrl} :
        (addr_in == REG_WAIT_WAKE)   ? {13'h0000, wait_wake_en} :
        (addr_in == REG_BACKUP_WAKE) ? {13'h0000, backup_wake_en} :
        (addr_in == REG_POWER_EN)    ? {29'h0000_0000, power_en} :
        (addr_in == REG_STATUS)      ? status_word :
        (addr_in == REG_IRQ_STATUS)  ? {29'h0000_0000, irq_status} :
        (addr_in == REG_IRQ_ENABLE)  ? {29'h0000_0000, irq_enable} : 32'h0000_0000;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out <= 32'h0000_0000;
        end else begin
            rd_data_out <= rd_en_in ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Clock and supply outputs
    // ------------------------------------------------------------
    wire logic running = state == ST_ACTIVE;
    wire logic clocked = running || state == ST_SLEEP;
    assign core_clk_en_out   = running;
    assign periph_clk_en_out = clocked && power_en[PWR_PERIPH_BIT];
    assign mem_clk_en_out    = clocked && power_en[PWR_MEM_BIT];
    assign master_clock_sel_out   = ctrl[CTRL_CLKSEL_LSB +: 2];
    assign fast_rc_osc_enable_out = ctrl[CTRL_RCEN_BIT] || state == ST_RC_RESTART;
    assign pll_enable_out     = ctrl[CTRL_PLLEN_BIT] && running;
    assign core_supply_en_out = core_supply;
    assign sram_supply_en_out = sram_supply;
    assign regulator_en_out   = core_supply;
    assign gpio_hold_out      = state == ST_BACKUP || state == ST_SUPPLY_UP;
    // Core comes back from backup through reset
    assign core_reset_out     = gpio_hold_out;
    assign fast_startup_req_out = fsr && state == ST_WAIT;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int WAIT_BOUND = WAIT_WAKE_MAX_CYC;

    sleep_clocks_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_SLEEP |-> !core_clk_en_out
            && periph_clk_en_out == power_en[PWR_PERIPH_BIT])
        else $error("Sleep clock gating wrong");

    sleep_entry_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_ACTIVE && wfi_in && !lps && !deep_sleep_select_in
            |=> state == ST_SLEEP && !core_clk_en_out)
        else $error("Sleep not entered");

    wfi_wake_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_SLEEP && by_wfi && !irq_pending_in |=> state == ST_SLEEP)
        else $error("Wait-for-interrupt sleep left without interrupt");

    resync_wait_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_ACTIVE && wfe_in && lps && !deep_sleep_select_in
            |=> (state == ST_RESYNC) [*4] ##1 state == ST_WAIT && !fast_rc_osc_enable_out)
        else $error("Wait entry resync wrong");

    wait_clocks_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_WAIT |-> !core_clk_en_out && !periph_clk_en_out
            && !mem_clk_en_out && core_supply_en_out && sram_supply_en_out)
        else $error("Wait mode clocks or supplies wrong");

    fast_start_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_WAIT && |(~wake_n & wait_wake_en) |-> fast_startup_req_out
            ##1 state == ST_RC_RESTART && fast_rc_osc_enable_out)
        else $error("Fast start-up missed");

    wait_wake_time_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_RC_RESTART |-> cnt < 16'(WAIT_BOUND - 1))
        else $error("Wait wake-up too slow");

    wake_on_rc_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(core_clk_en_out) && $past(state) != ST_SLEEP
            |-> master_clock_sel_out == CLK_FAST_RC && !pll_enable_out)
        else $error("Wake-up not on fast RC");

    backup_entry_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_ACTIVE && wfe_in && deep_sleep_select_in
            |=> state == ST_BACKUP && !core_supply_en_out && !regulator_en_out)
        else $error("Backup entry wrong");

    backup_wake_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_BACKUP && fsr |=> core_supply_en_out && sram_supply_en_out)
        else $error("Supplies not restored");

    gpio_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_BACKUP |-> gpio_hold_out && core_reset_out)
        else $error("GPIO not held in backup");

    wake_mask_a: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        state == ST_BACKUP && !(|(~wake_n & backup_wake_en)) |=> state == ST_BACKUP)
        else $error("Disabled source woke backup");
endmodule

// >>> hw/lpm_fast_startup.sv
// Clockless fast start-up request from the enabled low-level wake inputs
`timescale 1ns/1ps
module lpm_fast_startup #(
    parameter int N = 19
) (
    // Wake inputs, active low
    input  wire logic [N-1:0] wake_n_in,
    // Per-source enables
    input  wire logic [N-1:0] wake_en_in,
    // Request to the power management controller
    output logic              fast_startup_req_out
);
    // Pure gates: works while every clock is stopped
    assign fast_startup_req_out = |(~wake_n_in & wake_en_in);
endmodule

// >>> hw/lpm_pkg.sv
// Constants, register map and types of the low-power mode controller
// Overview of operation
// - Wait mode starts after main-clock resync cycles and clears fast_rc_osc_enable on entry, which firmware may poll.
// - Sleep mode stops the core clock and the PLL; enabled peripheral clocks keep running.
// - Wait-for-interrupt or wait-for-event with low_power_select and deep_sleep_select both 0 enters sleep mode.
// - Sleep entered by wait-for-interrupt wakes on an interrupt only; by wait-for-event also on any event or enabled wake source.
// - Each powered part and each wake source has its own enable; wake enables are set separately for wait and backup mode.
// - A wake event in backup mode re-enables the core and SRAM supplies, each only if it is off.
// - In wait mode a low level on any enabled one of the 19 wake inputs triggers a fast start-up.
// - Fast start-up detection needs no clock and drives a request into the power management controller.
// - On that request the fast RC oscillator restarts, then the master clock moves to it as the core clock returns.
// - After a wake-up from wait or backup mode the device runs from the fast RC oscillator and leaves the PLL off.
// - Wake-up takes under 10 us from wait mode and under 0.1 ms from backup mode.
// - Wait-for-event with deep_sleep_select at 1 enters backup mode with core supply and regulator off.
// - Wait mode stops core, peripheral and memory clocks while all supplies stay on.
// - General-purpose I/O state is held while in backup mode.
package lpm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int WAIT_WAKE_MAX_NS  = 10000;
    localparam int BACKUP_WAKE_MAX_NS = 100000;
    localparam int RC_START_NS       = 2000;
    localparam int SUPPLY_RAMP_NS    = 50000;
    localparam int RESYNC_CYC        = 4;
    // Longest times round down, least times round up
    localparam int WAIT_WAKE_MAX_CYC   = WAIT_WAKE_MAX_NS * 1000 / CLK_PERIOD_PS;
    localparam int BACKUP_WAKE_MAX_CYC = BACKUP_WAKE_MAX_NS * 1000 / CLK_PERIOD_PS;
    localparam int RC_START_CYC        = (RC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SUPPLY_RAMP_CYC     = (SUPPLY_RAMP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_WAIT_WAKE   = 8'h04;
    localparam logic [7:0] REG_BACKUP_WAKE = 8'h08;
    localparam logic [7:0] REG_POWER_EN    = 8'h0C;
    localparam logic [7:0] REG_STATUS      = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] REG_IRQ_ENABLE  = 8'h18;
    localparam logic [7:0] REG_IRQ_CLEAR   = 8'h1C;

    // Control fields
    localparam int CTRL_LPS_BIT    = 0;
    localparam int CTRL_RCEN_BIT   = 1;
    localparam int CTRL_CLKSEL_LSB = 2;
    localparam int CTRL_PLLEN_BIT  = 4;
    // Power enable fields
    localparam int PWR_PERIPH_BIT  = 0;
    localparam int PWR_MEM_BIT     = 1;
    localparam int PWR_SRAM_KEEP_BIT = 2;
    // Status fields
    localparam int STAT_MODE_LSB   = 0;
    localparam int STAT_CORE_BIT   = 2;
    localparam int STAT_SRAM_BIT   = 3;
    localparam int STAT_FSR_BIT    = 4;

    localparam int WAKE_SRC_N = 19;
    localparam int IRQ_N      = 3;
    localparam int IRQ_SLEEP_WAKE  = 0;
    localparam int IRQ_WAIT_WAKE   = 1;
    localparam int IRQ_BACKUP_WAKE = 2;

    localparam logic [1:0] CLK_FAST_RC = 2'h0;
    localparam logic [1:0] CLK_MAIN_OSC = 2'h1;
    localparam logic [1:0] CLK_PLL     = 2'h2;

    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_WAIT   = 2'h2;
    localparam logic [1:0] MODE_BACKUP = 2'h3;

    // Reset values
    localparam logic [4:0]  CTRL_RESET      = 5'h02;
    localparam logic [18:0] WAKE_EN_RESET   = 19'h0_0000;
    localparam logic [2:0]  POWER_EN_RESET  = 3'h3;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_RESYNC,
        ST_WAIT,
        ST_RC_RESTART,
        ST_BACKUP,
        ST_SUPPLY_UP
    } lpm_state_t;

endpackage

// >>> verification/lpm_core_model.sv
// Processor core model that executes the wait instructions
`timescale 1ns/1ps
module lpm_core_model (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic core_clk_en_in,
    input  wire logic do_wfi_in,
    input  wire logic do_wfe_in,
    output logic      wfi_out,
    output logic      wfe_out
);
    // ----------------------------------------
    // Instruction issue
    // ----------------------------------------
    // A stopped core executes nothing, so requests only issue while it is clocked
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wfi_out <= 1'b0;
            wfe_out <= 1'b0;
        end else begin
            wfi_out <= do_wfi_in & core_clk_en_in;
            wfe_out <= do_wfe_in & core_clk_en_in;
        end
    end
endmodule

// >>> verification/lpm_ctrl_tb.sv
// Self-checking testbench of the low-power mode controller
`timescale 1ns/1ps
module lpm_ctrl_tb;
    import lpm_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        wr_en = 1'b0, rd_en = 1'b0, rd_q = 1'b0, deep = 1'b0;
    logic        do_wfi = 1'b0, do_wfe = 1'b0, irq_pend = 1'b0, evt = 1'b0;
    logic [18:0] wake_n  = 19'h7_ffff;
    logic        wait_for_interrupt_instr, wait_for_event_instr, core_en, periph_en, mem_en, rc_en, pll_en;
    logic        core_sup, sram_sup, hold, fsr, irq, reg_en, core_rst;
    logic [1:0]  clk_sel;
    logic [31:0] rd_data;
    logic [31:0] exp_q[$];
    int          err_total = 0, samples_checked = 0, n, idx, seed = 32'h8621;

    always #2.5 ref_clk = ~ref_clk;

    lpm_ctrl #(.SUPPLY_RAMP_CYCLES(20), .BACKUP_WAKE_CYCLES(40)) dut_u (
        .ref_clk_in(ref_clk), .rstn_in(rstn), .addr_in(addr), .wr_data_in(wdata),
        .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
        .wfi_in(wait_for_interrupt_instr), .wfe_in(wait_for_event_instr), .deep_sleep_select_in(deep),
        .irq_pending_in(irq_pend), .event_in(evt),
        .wake_pin_inputs_n_in(wake_n[15:0]), .supply_monitor_n_in(wake_n[16]),
        .rtc_alarm_n_in(wake_n[17]), .realtime_timer_alarm_n_in(wake_n[18]),
        .core_clk_en_out(core_en), .periph_clk_en_out(periph_en), .mem_clk_en_out(mem_en),
        .master_clock_sel_out(clk_sel), .fast_rc_osc_enable_out(rc_en),
        .pll_enable_out(pll_en), .core_supply_en_out(core_sup),
        .sram_supply_en_out(sram_sup), .regulator_en_out(reg_en), .gpio_hold_out(hold),
        .core_reset_out(core_rst), .fast_startup_req_out(fsr), .irq_out(irq));

    lpm_core_model core_u (.clk_in(ref_clk), .rstn_in(rstn), .core_clk_en_in(core_en),
        .do_wfi_in(do_wfi), .do_wfe_in(do_wfe), .wfi_out(wait_for_interrupt_instr), .wfe_out(wait_for_event_instr));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask

    task conclude;
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd_en <= 1'b0;
    endtask

    task instr(input bit use_wfe);
        @(posedge ref_clk);
        if (use_wfe) do_wfe <= 1'b1;
        else do_wfi <= 1'b1;
        @(posedge ref_clk);
        do_wfe <= 1'b0;
        do_wfi <= 1'b0;
    endtask

    // Bounded wait on the core clock enable or the fast RC enable
    task wait_sig(input bit on_rc, input logic v, input int lim);
        n = 0;
        while ((on_rc ? rc_en : core_en) !== v && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if ((on_rc ? rc_en : core_en) !== v) begin
            err_total++;
            conclude();
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_q) check(rd_data, exp_q.pop_front());
        rd_q <= rd_en;
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(REG_CTRL, 32'h0000_0002);
        rd(REG_POWER_EN, 32'h0000_0003);
        rd(REG_STATUS, 32'h0000_000C);
        rd(8'h40, 32'h0000_0000);
        wr(REG_IRQ_ENABLE, 32'h0000_0007);
        instr(1'b0);
        wait_sig(1'b0, 1'b0, 10);
        check(periph_en, 1'b1);
        @(posedge ref_clk) evt <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 check(core_en, 1'b0);
        @(posedge ref_clk) evt <= 1'b0;
        irq_pend <= 1'b1;
        wait_sig(1'b0, 1'b1, 20);
        @(posedge ref_clk) irq_pend <= 1'b0;
        instr(1'b1);
        wait_sig(1'b0, 1'b0, 5);
        @(posedge ref_clk) evt <= 1'b1;
        wait_sig(1'b0, 1'b1, 5);
        @(posedge ref_clk) evt <= 1'b0;
        rd(REG_IRQ_STATUS, 32'h0000_0001);
        #1 check(irq, 1'b1);
        wr(REG_IRQ_CLEAR, 32'h0000_0001);
        @(posedge ref_clk) #1 check(irq, 1'b0);
        idx = ($random(seed) & 32'h7fff_ffff) % WAKE_SRC_N;
        wr(REG_WAIT_WAKE, 32'h0000_0001 << idx);
        wr(REG_CTRL, 32'h0000_0013);
        instr(1'b1);
        wait_sig(1'b0, 1'b0, 5);
        wait_sig(1'b1, 1'b0, 10);
        check({periph_en, mem_en, core_sup, fsr}, 4'h2);
        rd(REG_STATUS, 32'h0000_000E);
        @(posedge ref_clk) wake_n[idx] <= 1'b0;
        #1 check(fsr, 1'b1);
        wait_sig(1'b0, 1'b1, WAIT_WAKE_MAX_CYC);
        check({clk_sel, rc_en, pll_en}, {CLK_FAST_RC, 2'b10});
        @(posedge ref_clk) wake_n <= 19'h7_ffff;
        rd(REG_IRQ_STATUS, 32'h0000_0002);
        wr(REG_BACKUP_WAKE, 32'h0002_0000);
        wr(REG_CTRL, 32'h0000_000A);
        @(posedge ref_clk) deep <= 1'b1;
        instr(1'b1);
        wait_sig(1'b0, 1'b0, 5);
        repeat (2) @(posedge ref_clk);
        #1 check({core_sup, sram_sup, reg_en, hold, core_rst}, 5'h03);
        @(posedge ref_clk) wake_n[17] <= 1'b0;
        deep <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 check({core_sup, sram_sup}, 2'h3);
        wait_sig(1'b0, 1'b1, 40);
        check({clk_sel, hold, core_rst, reg_en}, {CLK_FAST_RC, 3'b001});
        @(posedge ref_clk) wake_n <= 19'h7_ffff;
        rd(REG_IRQ_STATUS, 32'h0000_0006);
        repeat (2) @(posedge ref_clk);
        conclude();
    end
endmodule
